// file: src/cfsp_core_regs.sv
// cfsp_core_regs.sv: condition flag register, stack pointer and pending interrupt latch
// assumes the core drives ops, push/pop and interrupt entry on clk
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cfsp_params.svh"

// Behaviour
// - 8-bit flags, top three ones, mask resets set
// - flags saved and restored via stack
// - add sets half carry from bit three
// - interrupt entry or software sets mask
// - mask cleared only by software ops
// - masked requests latched as pending
// - entry masks, return restores saved mask
// - unmasked handler services pending regardless priority
// - negative flag copies result bit seven
// - zero flag set when result is zero
// - carry from overflow, forced by carry ops
// - bit test, shift, rotate update carry
// - branch conditions test flags in pairs
// - 16-bit stack pointer resets to 01FF
// - decrement after push, increment before pop
// - upper nine stack pointer bits fixed
module cfsp_core_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire cfsp_pkg::cfsp_op_t op,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire cfsp_pkg::cfsp_cond_t br_cond,
  input wire logic push,
  input wire logic pop,
  input wire logic push_flags,
  input wire logic [7:0] pop_data,
  input wire logic pop_flags,
  input wire logic irq_entry,
  input wire logic return_from_interrupt,
  input wire logic [`CFSP_NIRQ-1:0] irq_req,
  input wire logic [`CFSP_NIRQ-1:0] irq_ack,
  input wire logic [`CFSP_ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic [7:0] result,
  output logic [7:0] cond_flags_reg,
  output logic [15:0] stack_ptr,
  output logic [15:0] stack_addr,
  output logic [7:0] push_data,
  output logic branch_taken,
  output logic [`CFSP_NIRQ-1:0] irq_pending,
  output logic irq_service
);
  // ====================================
  // alu
  logic [7:0] alu_res;
  logic alu_h;
  logic alu_c;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [15:0] sp_r;
  logic [15:0] sp_nxt;
  logic [`CFSP_NIRQ-1:0] pend_r;

  cfsp_flag_alu u_alu (
    .op(op),
    .opa(opa),
    .opb(opb),
    .carry_in(flags_r[`CFSP_BIT_C]),
    .result(alu_res),
    .half_carry(alu_h),
    .carry_out(alu_c)
  );

  // fixed bits forced into any flag value
  function automatic logic [7:0] fix_flags(input logic [7:0] v);
    fix_flags = v | `CFSP_FLAGS_FIXED;
  endfunction : fix_flags

  // low bits move, upper bits held
  function automatic logic [15:0] sp_step(input logic [15:0] v, input logic up);
    logic [`CFSP_SP_LOW_W-1:0] low;
    low = up ? v[`CFSP_SP_LOW_W-1:0] + 7'h01 : v[`CFSP_SP_LOW_W-1:0] - 7'h01;
    sp_step = `CFSP_SP_FIXED | {9'h000, low};
  endfunction : sp_step

  // branch condition evaluation
  function automatic logic cond_true(input cfsp_pkg::cfsp_cond_t c, input logic [7:0] f);
    cond_true = 1'b0;
    unique case (c)
      cfsp_pkg::CFSP_BR_HALF_CARRY: cond_true = f[`CFSP_BIT_H];
      cfsp_pkg::CFSP_BR_NO_HALF_CARRY: cond_true = !f[`CFSP_BIT_H];
      cfsp_pkg::CFSP_BR_MASKED: cond_true = f[`CFSP_BIT_I];
      cfsp_pkg::CFSP_BR_UNMASKED: cond_true = !f[`CFSP_BIT_I];
      cfsp_pkg::CFSP_BR_MINUS: cond_true = f[`CFSP_BIT_N];
      cfsp_pkg::CFSP_BR_PLUS: cond_true = !f[`CFSP_BIT_N];
      cfsp_pkg::CFSP_BR_EQUAL: cond_true = f[`CFSP_BIT_Z];
      cfsp_pkg::CFSP_BR_NOT_EQUAL: cond_true = !f[`CFSP_BIT_Z];
      cfsp_pkg::CFSP_BR_CARRY: cond_true = f[`CFSP_BIT_C];
      cfsp_pkg::CFSP_BR_NO_CARRY: cond_true = !f[`CFSP_BIT_C];
      default: cond_true = 1'b0;
    endcase
  endfunction : cond_true

  // ====================================
  // flag next value, priority: reset-free order below
  always_comb begin
    flags_nxt = flags_r;
    unique case (op)
      cfsp_pkg::CFSP_OP_ADD, cfsp_pkg::CFSP_OP_ADC: begin
        flags_nxt[`CFSP_BIT_H] = alu_h;
        flags_nxt[`CFSP_BIT_C] = alu_c;
      end
      cfsp_pkg::CFSP_OP_SUB: flags_nxt[`CFSP_BIT_C] = alu_c;
      cfsp_pkg::CFSP_OP_SHIFT, cfsp_pkg::CFSP_OP_BTJ: flags_nxt[`CFSP_BIT_C] = alu_c;
      cfsp_pkg::CFSP_OP_CLR_MASK: flags_nxt[`CFSP_BIT_I] = 1'b0;
      cfsp_pkg::CFSP_OP_SET_MASK: flags_nxt[`CFSP_BIT_I] = 1'b1;
      cfsp_pkg::CFSP_OP_FORCE_CARRY: flags_nxt[`CFSP_BIT_C] = 1'b1;
      cfsp_pkg::CFSP_OP_CLEAR_CARRY: flags_nxt[`CFSP_BIT_C] = 1'b0;
      default: flags_nxt = flags_r;
    endcase
    // result flags from data operations
    if (op == cfsp_pkg::CFSP_OP_ADD || op == cfsp_pkg::CFSP_OP_ADC || op == cfsp_pkg::CFSP_OP_SUB ||
        op == cfsp_pkg::CFSP_OP_LOGIC || op == cfsp_pkg::CFSP_OP_SHIFT) begin
      flags_nxt[`CFSP_BIT_N] = alu_res[7];
      flags_nxt[`CFSP_BIT_Z] = (alu_res == 8'h00);
    end
    // restore from stack, return brings back saved mask
    if (pop_flags || return_from_interrupt) begin
      flags_nxt = pop_data;
    end
    // software register write
    if (wr && addr == `CFSP_ADDR_FLAGS) begin
      flags_nxt = wdata[7:0];
    end
    // interrupt entry masks last, so it always wins
    if (irq_entry) begin
      flags_nxt[`CFSP_BIT_I] = 1'b1;
    end
    flags_nxt = fix_flags(flags_nxt);
  end

  // flag register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_r <= `CFSP_FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ====================================
  // stack pointer next value
  always_comb begin
    sp_nxt = sp_r;
    if (wr && addr == `CFSP_ADDR_SP) begin
      sp_nxt = `CFSP_SP_FIXED | (wdata & `CFSP_SP_LOW_MASK);
    end else if (push) begin
      sp_nxt = sp_step(sp_r, 1'b0);
    end else if (pop) begin
      sp_nxt = sp_step(sp_r, 1'b1);
    end
  end

  // stack pointer register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sp_r <= `CFSP_SP_RST;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // stack access address: current on push, pre-incremented on pop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stack_addr <= `CFSP_SP_RST;
      push_data <= 8'h00;
    end else begin
      stack_addr <= pop ? sp_step(sp_r, 1'b1) : sp_r;
      push_data <= push_flags ? flags_r : opa;
    end
  end

  // ====================================
  // pending interrupts; a new request beats an ack
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_r <= `CFSP_IRQ_NONE;
    end else begin
      pend_r <= (pend_r & ~irq_ack) | irq_req;
    end
  end

  // service request whenever unmasked with a request pending, priority left to the core
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_service <= 1'b0;
    end else begin
      irq_service <= (|pend_r) && !flags_r[`CFSP_BIT_I];
    end
  end

  // ====================================
  // registered outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result <= 8'h00;
      branch_taken <= 1'b0;
    end else begin
      result <= alu_res;
      branch_taken <= cond_true(br_cond, flags_r);
    end
  end

  // register read port, data in next cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        `CFSP_ADDR_FLAGS: rdata <= {8'h00, flags_r};
        `CFSP_ADDR_SP: rdata <= sp_r;
        `CFSP_ADDR_PEND: rdata <= {8'h00, pend_r};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  assign cond_flags_reg = flags_r;
  assign stack_ptr = sp_r;
  assign irq_pending = pend_r;
endmodule : cfsp_core_regs
`default_nettype wire

// file: common/cfsp_params.svh
// cfsp_params.svh: named constants for the flag register and stack pointer block
// assumes inclusion by bare name from design and bench files
`ifndef CFSP_PARAMS_SVH
`define CFSP_PARAMS_SVH

// ====================================
// register addresses on the plain port
`define CFSP_ADDR_W 4
`define CFSP_ADDR_FLAGS 4'h0
`define CFSP_ADDR_SP 4'h1
`define CFSP_ADDR_PEND 4'h2

// ====================================
// flag register layout
`define CFSP_BIT_H 4
`define CFSP_BIT_I 3
`define CFSP_BIT_N 2
`define CFSP_BIT_Z 1
`define CFSP_BIT_C 0
`define CFSP_FLAGS_FIXED 8'h00e0
`define CFSP_FLAGS_RST 8'h00e8

// ====================================
// stack pointer
`define CFSP_SP_RST 16'h01ff
`define CFSP_SP_FIXED 16'h0180
`define CFSP_SP_LOW_W 7
`define CFSP_SP_LOW_MASK 16'h007f

// ====================================
// interrupt sources
`define CFSP_NIRQ 8
`define CFSP_IRQ_NONE 8'h0000

`endif

// file: common/cfsp_pkg.sv
// cfsp_pkg.sv: operation and branch condition types
// assumes nothing beyond the params header
package cfsp_pkg;
  // alu and flag operations issued by the core
  typedef enum logic [3:0] {
    CFSP_OP_NONE,
    CFSP_OP_ADD,
    CFSP_OP_ADC,
    CFSP_OP_SUB,
    CFSP_OP_LOGIC,
    CFSP_OP_SHIFT,
    CFSP_OP_BTJ,
    CFSP_OP_CLR_MASK,
    CFSP_OP_SET_MASK,
    CFSP_OP_FORCE_CARRY,
    CFSP_OP_CLEAR_CARRY
  } cfsp_op_t;

  // branch conditions, complementary pairs
  typedef enum logic [3:0] {
    CFSP_BR_HALF_CARRY,
    CFSP_BR_NO_HALF_CARRY,
    CFSP_BR_MASKED,
    CFSP_BR_UNMASKED,
    CFSP_BR_MINUS,
    CFSP_BR_PLUS,
    CFSP_BR_EQUAL,
    CFSP_BR_NOT_EQUAL,
    CFSP_BR_CARRY,
    CFSP_BR_NO_CARRY
  } cfsp_cond_t;
endpackage : cfsp_pkg

// file: src/cfsp_flag_alu.sv
// cfsp_flag_alu.sv: combinational 8-bit alu computing result and flag candidates
// assumes operands from the core on the same clock
`timescale 1ns/1ps
`default_nettype none
module cfsp_flag_alu (
  input wire cfsp_pkg::cfsp_op_t op,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic half_carry,
  output logic carry_out
);
  logic [8:0] sum;
  logic [4:0] low_sum;

  // add, add with carry, subtract, logic, shift
  always_comb begin
    sum = 9'h000;
    low_sum = 5'h00;
    result = 8'h00;
    half_carry = 1'b0;
    carry_out = 1'b0;
    unique case (op)
      cfsp_pkg::CFSP_OP_ADD, cfsp_pkg::CFSP_OP_ADC: begin
        sum = {1'b0, opa} + {1'b0, opb} + {8'h00, (op == cfsp_pkg::CFSP_OP_ADC) & carry_in};
        low_sum = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, (op == cfsp_pkg::CFSP_OP_ADC) & carry_in};
        result = sum[7:0];
        half_carry = low_sum[4];
        carry_out = sum[8];
      end
      cfsp_pkg::CFSP_OP_SUB: begin
        sum = {1'b0, opa} - {1'b0, opb};
        result = sum[7:0];
        carry_out = sum[8]; // borrow
      end
      cfsp_pkg::CFSP_OP_LOGIC: begin
        result = opa & opb;
      end
      cfsp_pkg::CFSP_OP_SHIFT: begin
        result = {opa[6:0], carry_in}; // rotate left through carry
        carry_out = opa[7];
      end
      cfsp_pkg::CFSP_OP_BTJ: begin
        result = opa;
        carry_out = |(opa & opb); // tested bit goes to carry
      end
      default: begin
        result = opa;
      end
    endcase
  end
endmodule : cfsp_flag_alu
`default_nettype wire

// file: sim/cfsp_core_regs_monitor.sv
// cfsp_core_regs_monitor.sv: checks on flags, stack pointer and pending latch
// assumes binding to cfsp_core_regs, one clock, rstn synchronous
`timescale 1ns/1ps
`default_nettype none
`include "cfsp_params.svh"
module cfsp_core_regs_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire cfsp_pkg::cfsp_op_t op,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic push,
  input wire logic pop,
  input wire logic pop_flags,
  input wire logic irq_entry,
  input wire logic return_from_interrupt,
  input wire logic [`CFSP_NIRQ-1:0] irq_req,
  input wire logic [`CFSP_ADDR_W-1:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic [7:0] result,
  input wire logic [7:0] cond_flags_reg,
  input wire logic [15:0] stack_ptr,
  input wire logic [`CFSP_NIRQ-1:0] irq_pending,
  input wire logic irq_service
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ====================
  // helpers
  logic quiet;
  logic nz_op;
  logic [4:0] nib;
  logic nib_carry;
  logic mask_src;
  logic svc_ok;
  // no flag source above the alu this cycle
  assign quiet = !pop_flags && !return_from_interrupt && !wr && !irq_entry;
  assign nz_op = op >= cfsp_pkg::CFSP_OP_ADD && op <= cfsp_pkg::CFSP_OP_SHIFT;
  assign nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
  assign nib_carry = nib[4];
  // software sources allowed to clear the mask
  assign mask_src = op == cfsp_pkg::CFSP_OP_CLR_MASK || return_from_interrupt || pop_flags || wr;
  // service allowed: unmasked with something pending
  assign svc_ok = !cond_flags_reg[3] && |irq_pending;
  // ====================
  // assertions
  a_fixed_ones: assert property (cond_flags_reg[7:5] == 3'h7)
    else $error("flag top bits not ones");
  a_sp_fixed: assert property (stack_ptr[15:7] == 9'h003)
    else $error("stack pointer upper bits moved");
  a_sign_zero: assert property (nz_op && quiet |=>
    cond_flags_reg[2] == result[7] && cond_flags_reg[1] == (result == 8'h00)) else $error("sign or zero flag wrong");
  a_half_carry: assert property (op == cfsp_pkg::CFSP_OP_ADD && quiet |=>
    cond_flags_reg[4] == $past(nib_carry)) else $error("half carry wrong");
  a_entry_masks: assert property (irq_entry |=> cond_flags_reg[3])
    else $error("entry left mask clear");
  a_mask_clear: assert property ($fell(cond_flags_reg[3]) |->
    $past(mask_src)) else $error("mask cleared");
  a_push_dec: assert property (push && !wr |=>
    stack_ptr[6:0] == $past(stack_ptr[6:0]) - 7'h01) else $error("push step wrong");
  a_pop_inc: assert property (pop && !push && !wr |=>
    stack_ptr[6:0] == $past(stack_ptr[6:0]) + 7'h01) else $error("pop step wrong");
  a_pend_latch: assert property (|irq_req |=>
    (irq_pending & $past(irq_req)) == $past(irq_req)) else $error("request not latched");
  a_service_gate: assert property (irq_service |->
    $past(svc_ok)) else $error("service while masked");
  a_read_sp: assert property (rd && addr == `CFSP_ADDR_SP |=> rdata == $past(stack_ptr))
    else $error("pointer read wrong");
  // main scenarios
  c_service: cover property (irq_service);
  c_push_pop: cover property (push ##1 !push [*1] ##1 pop);
  c_unmask: cover property ($fell(cond_flags_reg[3]));
endmodule : cfsp_core_regs_monitor
`default_nettype wire

// file: sim/cfsp_stack_mem.sv
// cfsp_stack_mem.sv: core side stack memory answering pushes and pops
// assumes push_data and stack_addr registered one cycle after push
`timescale 1ns/1ps
`default_nettype none
module cfsp_stack_mem (
  input wire logic clk,
  input wire logic push,
  input wire logic pop,
  input wire logic [15:0] stack_ptr,
  input wire logic [15:0] stack_addr,
  input wire logic [7:0] push_data,
  output logic [7:0] pop_data
);
  logic [7:0] mem_r [0:127];
  logic push_q_r;
  // store the byte once the block has registered it
  always_ff @(posedge clk) begin
    push_q_r <= push;
    if (push_q_r) begin
      mem_r[stack_addr[6:0]] <= push_data;
    end
  end
  // popped byte sits above the pointer; idle lines toggle
  assign pop_data = pop ? mem_r[stack_ptr[6:0] + 7'h01] : (8'ha5 ^ {8{clk}});
endmodule : cfsp_stack_mem
`default_nettype wire

// file: sim/testbench.sv
// testbench.sv: directed scenarios for cfsp_core_regs
// assumes the stack memory model and monitor in sim/
`timescale 1ns/1ps
`default_nettype none
`include "cfsp_params.svh"
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  cfsp_pkg::cfsp_op_t op = cfsp_pkg::CFSP_OP_NONE;
  cfsp_pkg::cfsp_cond_t br_cond = cfsp_pkg::CFSP_BR_HALF_CARRY;
  logic [7:0] opa = 8'h00, opb = 8'h00, irq_req = 8'h00, irq_ack = 8'h00;
  logic push = 1'b0, pop = 1'b0, push_flags = 1'b0, pop_flags = 1'b0;
  logic irq_entry = 1'b0, return_from_interrupt = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, stack_ptr, stack_addr;
  logic [7:0] pop_data, result, cond_flags_reg, push_data, irq_pending;
  logic branch_taken, irq_service;
  int num_errors = 0, cmp_count = 0, cycles = 0;
  always #12.5 clk = ~clk;
  cfsp_core_regs cfsp_core_regs_inst (.clk, .rstn, .op, .opa, .opb, .br_cond, .push, .pop, .push_flags,
    .pop_data, .pop_flags, .irq_entry, .return_from_interrupt, .irq_req, .irq_ack, .addr, .wdata, .wr, .rd,
    .rdata, .result, .cond_flags_reg, .stack_ptr, .stack_addr, .push_data, .branch_taken, .irq_pending, .irq_service);
  cfsp_stack_mem cfsp_stack_mem_inst (.clk, .push, .pop, .stack_ptr, .stack_addr, .push_data, .pop_data);
  // ====================
  // report
  task finish_test;
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      finish_test();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ====================
  // register port
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_reg
  // one alu op, masked compare of result and flags
  task alu(input cfsp_pkg::cfsp_op_t o, input logic [7:0] a, b, r, rm, f, fm);
    @(posedge clk);
    op <= o;
    opa <= a;
    opb <= b;
    @(posedge clk);
    op <= cfsp_pkg::CFSP_OP_NONE;
    #1 chk(16'(result & rm), 16'(r));
    chk(16'(cond_flags_reg & fm), 16'(f));
  endtask : alu
  // bit i is the expected outcome of condition i
  task branches(input logic [9:0] e);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      br_cond <= cfsp_pkg::cfsp_cond_t'(i);
      @(posedge clk);
      #1 chk(16'(branch_taken), 16'(e[i]));
    end
  endtask : branches
  // ====================
  // scenarios
  task t_reset;
    rd_reg(`CFSP_ADDR_FLAGS, 16'h00e8);
    rd_reg(`CFSP_ADDR_SP, 16'h01ff);
    rd_reg(4'hf, 16'h0000);
    branches(10'h2a6);
  endtask : t_reset
  task t_alu;
    alu(cfsp_pkg::CFSP_OP_ADD, 8'h0f, 8'h01, 8'h10, 8'hff, 8'h10, 8'h17);
    alu(cfsp_pkg::CFSP_OP_ADD, 8'hff, 8'h01, 8'h00, 8'hff, 8'h13, 8'h17);
    branches(10'h165);
    alu(cfsp_pkg::CFSP_OP_SUB, 8'h00, 8'h01, 8'hff, 8'hff, 8'h05, 8'h07);
    alu(cfsp_pkg::CFSP_OP_ADC, 8'h07, 8'h08, 8'h10, 8'hff, 8'h10, 8'h17);
    alu(cfsp_pkg::CFSP_OP_FORCE_CARRY, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01);
    alu(cfsp_pkg::CFSP_OP_CLEAR_CARRY, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01);
    alu(cfsp_pkg::CFSP_OP_SHIFT, 8'h80, 8'h00, 8'h00, 8'hff, 8'h03, 8'h07);
    alu(cfsp_pkg::CFSP_OP_BTJ, 8'h08, 8'h04, 8'h08, 8'hff, 8'h00, 8'h01);
    alu(cfsp_pkg::CFSP_OP_LOGIC, 8'hf0, 8'h8f, 8'h80, 8'hff, 8'h04, 8'h06);
  endtask : t_alu
  task t_irq;
    @(posedge clk);
    irq_req <= 8'h04;
    @(posedge clk);
    irq_req <= 8'h00;
    #1 chk(16'(irq_pending), 16'h0004);
    @(posedge clk);
    op <= cfsp_pkg::CFSP_OP_CLR_MASK;
    @(posedge clk);
    op <= cfsp_pkg::CFSP_OP_NONE;
    #1 chk(16'(irq_service), 16'h0000);
    chk(16'(cond_flags_reg[3]), 16'h0000);
    @(posedge clk);
    irq_ack <= 8'h04;
    #1 chk(16'(irq_service), 16'h0001);
    @(posedge clk);
    irq_ack <= 8'h00;
    push <= 1'b1;
    push_flags <= 1'b1;
    #1 chk(16'(irq_pending), 16'h0000);
    @(posedge clk);
    push <= 1'b0;
    push_flags <= 1'b0;
    irq_entry <= 1'b1;
    #1 chk(stack_addr, 16'h01ff);
    chk(16'(push_data), 16'h00f4);
    @(posedge clk);
    irq_entry <= 1'b0;
    #1 chk(16'(cond_flags_reg[3]), 16'h0001);
    @(posedge clk);
    pop <= 1'b1;
    return_from_interrupt <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    return_from_interrupt <= 1'b0;
    #1 chk(16'(cond_flags_reg[3]), 16'h0000);
    chk(16'(cond_flags_reg), 16'h00f4);
    chk(stack_ptr, 16'h01ff);
    chk(stack_addr, 16'h01ff);
    alu(cfsp_pkg::CFSP_OP_SET_MASK, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h08);
  endtask : t_irq
  task t_sp;
    wr_reg(`CFSP_ADDR_SP, 16'hff80);
    rd_reg(`CFSP_ADDR_SP, 16'h0180);
    @(posedge clk);
    push <= 1'b1;
    repeat (2) @(posedge clk);
    push <= 1'b0;
    pop <= 1'b1;
    #1 chk(stack_ptr, 16'h01fe);
    repeat (2) @(posedge clk);
    pop <= 1'b0;
    #1 chk(stack_ptr, 16'h0180);
    wr_reg(`CFSP_ADDR_FLAGS, 16'h0000);
    rd_reg(`CFSP_ADDR_FLAGS, 16'h00e0);
  endtask : t_sp
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_alu();
    t_irq();
    t_sp();
    finish_test();
  end
endmodule : testbench
bind cfsp_core_regs cfsp_core_regs_monitor cfsp_core_regs_monitor_inst (.clk, .rstn, .op, .opa, .opb, .push,
  .pop, .pop_flags, .irq_entry, .return_from_interrupt, .irq_req, .addr, .wr, .rd, .rdata, .result,
  .cond_flags_reg, .stack_ptr, .irq_pending, .irq_service);
`default_nettype wire
